// ### rtl/fb_status_pkg.sv
package fb_status_pkg;

  // ==========================================================
  // Timing and reset constants
  // ==========================================================
  // Bus exchanges needed for a clear; a load acceptance needs one fewer
  localparam int unsigned XCHG_CYCLES = 4;
  localparam logic [2:0] XCHG_CNT_W3 = 3'h4;
  localparam logic [2:0] CNT_RST = 3'h0;

  // ==========================================================
  // Carriers
  // ==========================================================
  // Raw fault causes from the pin supervisors
  typedef struct packed {
    logic enc_supply;
    logic out1;
    logic out2;
    logic enc_signal;
  } fault_src_t;

  // Load request bits of one control image
  typedef struct packed {
    logic load_direct;
    logic load_preset;
    logic cmp1_load;
    logic cmp2_load;
    logic out_param_update;
  } load_req_t;

  // Counter events, one-cycle pulses
  typedef struct packed {
    logic high_limit;
    logic low_limit;
    logic zero_cross;
    logic sync_done;
  } cnt_evt_t;

  // Latched flags shown in the feedback image
  typedef struct packed {
    logic enc_supply_fault;
    logic out1_fault;
    logic out2_fault;
    logic enc_signal_fault;
    logic cmp1_flag;
    logic cmp2_flag;
    logic high_limit_flag;
    logic low_limit_flag;
    logic zero_cross_flag;
    logic sync_done_flag;
  } flags_t;

  localparam flags_t FLAGS_RST = '0;

  // Status-clear handshake states
  typedef enum logic [1:0] {CLR_IDLE, CLR_WAIT, CLR_DONE} clr_state_t;

endpackage

// ### rtl/counter_feedback_status.sv
`timescale 1ns/10ps
module counter_feedback_status
  import fb_status_pkg::*;
#(
  parameter int unsigned XCHG_COUNT = XCHG_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic xchg_i,
  input wire fault_src_t fault_src_i,
  input wire logic [3:0] diag_en_i,
  input wire logic error_ack_i,
  input wire logic host_stop_i,
  input wire load_req_t load_req_i,
  input wire logic load_value_bad_i,
  input wire logic param_bad_i,
  input wire logic status_clear_req_i,
  input wire cnt_evt_t cnt_evt_i,
  input wire logic no_main_dir_i,
  input wire logic out1_on_i,
  input wire logic out2_on_i,
  input wire logic out1_enable_i,
  input wire logic out2_enable_i,
  input wire logic out1_force_i,
  input wire logic out2_force_i,
  input wire logic input_pin_i,
  input wire logic gate_open_i,
  output logic input_pin_state_o,
  output logic out1_state_o,
  output logic out2_state_o,
  output logic gate_open_state_o,
  output logic load_busy_o,
  output logic load_accept_o,
  output logic load_conflict_error_o,
  output logic setting_error_o,
  output logic status_clear_active_o,
  output flags_t flags_o,
  output logic [3:0] diag_msg_o
);

  // ==========================================================
  // Internal state
  // ==========================================================
  flags_t flags_d;
  clr_state_t clr_q;
  logic [2:0] clr_cnt_q;
  logic [2:0] load_cnt_q;
  logic clr_now;
  logic ack_live;
  logic [3:0] fsrc;
  logic [3:0] fcur;
  logic multi_load;
  logic any_load;
  // Count value at the last exchange of a clear or load
  localparam logic [2:0] XCHG_LAST = 3'(XCHG_COUNT - 1);

  // Counters are three bits; one exchange leaves no busy phase
  if (XCHG_COUNT < 2 || XCHG_COUNT > 8) begin : g_count_check
    $error("XCHG_COUNT must lie between 2 and 8");
  end

  // Number of set bits in a load request
  function automatic logic [2:0] ones5(input load_req_t r);
    ones5 = 3'(r.load_direct) + 3'(r.load_preset) + 3'(r.cmp1_load)
          + 3'(r.cmp2_load) + 3'(r.out_param_update);
  endfunction

  assign fsrc = {fault_src_i.enc_supply, fault_src_i.out1,
                 fault_src_i.out2, fault_src_i.enc_signal};
  assign fcur = {flags_o.enc_supply_fault, flags_o.out1_fault,
                 flags_o.out2_fault, flags_o.enc_signal_fault};
  assign multi_load = ones5(load_req_i) > 3'h1;
  assign any_load = ones5(load_req_i) != 3'h0;
  assign ack_live = error_ack_i || host_stop_i;
  // clear pulse at end of handshake wait
  assign clr_now = (clr_q == CLR_WAIT) && xchg_i
                   && (clr_cnt_q == XCHG_LAST);

  // ==========================================================
  // Next value of latched flags
  // ==========================================================
  // Faults: set wins; events: set wins over clear
  always_comb begin
    flags_d = flags_o;
    if (ack_live) begin
      {flags_d.enc_supply_fault, flags_d.out1_fault,
       flags_d.out2_fault, flags_d.enc_signal_fault} = fsrc;
    end else begin
      {flags_d.enc_supply_fault, flags_d.out1_fault,
       flags_d.out2_fault, flags_d.enc_signal_fault} = fcur | fsrc;
    end
    if (clr_now) begin
      flags_d.cmp1_flag = 1'b0;
      flags_d.cmp2_flag = 1'b0;
      flags_d.high_limit_flag = 1'b0;
      flags_d.low_limit_flag = 1'b0;
      flags_d.zero_cross_flag = 1'b0;
      flags_d.sync_done_flag = 1'b0;
    end
    // comparator set, re-set if output on
    if (out1_on_i) flags_d.cmp1_flag = 1'b1;
    if (out2_on_i) flags_d.cmp2_flag = 1'b1;
    if (out1_force_i && !out1_enable_i) flags_d.cmp1_flag = 1'b1;
    if (out2_force_i && !out2_enable_i) flags_d.cmp2_flag = 1'b1;
    if (cnt_evt_i.high_limit) flags_d.high_limit_flag = 1'b1;
    if (cnt_evt_i.low_limit) flags_d.low_limit_flag = 1'b1;
    if (cnt_evt_i.zero_cross && no_main_dir_i) begin
      flags_d.zero_cross_flag = 1'b1;
    end
    if (cnt_evt_i.sync_done) flags_d.sync_done_flag = 1'b1;
  end

  // ==========================================================
  // Flag registers
  // ==========================================================
  // reset clears flags
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= FLAGS_RST;
    end else if (clk_en_i) begin
      flags_o <= flags_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_msg_o <= 4'h0;
    end else if (clk_en_i) begin
      diag_msg_o <= fcur & diag_en_i;
    end
  end

  // ==========================================================
  // Status-clear handshake
  // ==========================================================
  // four exchanges then clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_q <= CLR_IDLE;
      clr_cnt_q <= CNT_RST;
    end else if (clk_en_i) begin
      case (clr_q)
        CLR_IDLE: begin
          clr_cnt_q <= CNT_RST;
          if (status_clear_req_i) clr_q <= CLR_WAIT;
        end
        CLR_WAIT: begin
          if (xchg_i) begin
            clr_cnt_q <= clr_cnt_q + 3'h1;
            if (clr_now) clr_q <= CLR_DONE;
          end
        end
        CLR_DONE: begin
          if (!status_clear_req_i) clr_q <= CLR_IDLE;
        end
        default: clr_q <= CLR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_clear_active_o <= 1'b0;
    end else if (clk_en_i) begin
      status_clear_active_o <= (clr_q != CLR_IDLE) || status_clear_req_i;
    end
  end

  // ==========================================================
  // Load function
  // ==========================================================
  // busy for three exchanges, reject bad values
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_cnt_q <= CNT_RST;
      load_busy_o <= 1'b0;
      load_accept_o <= 1'b0;
    end else if (clk_en_i) begin
      load_accept_o <= 1'b0;
      if (load_cnt_q == CNT_RST) begin
        if (any_load && !multi_load && !load_value_bad_i) begin
          load_cnt_q <= 3'h1;
          load_busy_o <= 1'b1;
        end
      end else if (xchg_i) begin
        if (load_cnt_q == XCHG_LAST) begin
          load_cnt_q <= CNT_RST;
          load_busy_o <= 1'b0;
          load_accept_o <= 1'b1;
        end else begin
          load_cnt_q <= load_cnt_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_conflict_error_o <= 1'b0;
    end else if (clk_en_i) begin
      if (multi_load || (any_load && load_value_bad_i)) begin
        load_conflict_error_o <= 1'b1;
      end else if (any_load) begin
        load_conflict_error_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Live states
  // ==========================================================
  // live mirrors
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setting_error_o <= 1'b0;
      input_pin_state_o <= 1'b0;
      out1_state_o <= 1'b0;
      out2_state_o <= 1'b0;
      gate_open_state_o <= 1'b0;
    end else if (clk_en_i) begin
      setting_error_o <= param_bad_i;
      input_pin_state_o <= input_pin_i;
      out1_state_o <= out1_on_i;
      out2_state_o <= out2_on_i;
      gate_open_state_o <= gate_open_i;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_fault_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && !error_ack_i && !host_stop_i && flags_o.out1_fault
      |=> flags_o.out1_fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault flag dropped without ack");

  property p_fault_set;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && fault_src_i.enc_supply |=> flags_o.enc_supply_fault;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("supply fault not latched");

  property p_cmp_reset;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && out1_on_i |=> flags_o.cmp1_flag;
  endproperty
  a_cmp_reset: assert property (p_cmp_reset)
    else $error("cmp1 flag not set while output on");

  property p_force;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && out2_force_i && !out2_enable_i |=> flags_o.cmp2_flag;
  endproperty
  a_force: assert property (p_force)
    else $error("cmp2 flag not set by force");

  property p_conflict;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && $countones(load_req_i) > 1 && !load_busy_o
      |=> load_conflict_error_o && !load_busy_o;
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("load conflict not reported");

  property p_sync_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && flags_o.sync_done_flag && !clr_now
      |=> flags_o.sync_done_flag;
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync flag lost without clear");

  property p_clr_active;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && status_clear_req_i |=> status_clear_active_o;
  endproperty
  a_clr_active: assert property (p_clr_active)
    else $error("clear activity not shown");

  property p_mirror;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i |=> out1_state_o == $past(out1_on_i)
               && input_pin_state_o == $past(input_pin_i);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("output state mirror wrong");

  property p_cmp_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && flags_o.cmp1_flag && !clr_now |=> flags_o.cmp1_flag;
  endproperty
  a_cmp_hold: assert property (p_cmp_hold)
    else $error("cmp1 flag lost without clear");

  property p_clr_done;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && clr_now && !cnt_evt_i.high_limit
      |=> !flags_o.high_limit_flag;
  endproperty
  a_clr_done: assert property (p_clr_done)
    else $error("high limit flag not cleared");

  property p_bad_value;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && $countones(load_req_i) == 1 && load_value_bad_i
      && !load_busy_o |=> load_conflict_error_o && !load_busy_o;
  endproperty
  a_bad_value: assert property (p_bad_value)
    else $error("bad load value not rejected");

  property p_load_done;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      load_accept_o && $past(clk_en_i) |-> $past(xchg_i) && !load_busy_o;
  endproperty
  a_load_done: assert property (p_load_done)
    else $error("load accepted off an exchange");

  c_clear: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clr_now);
  c_load: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    load_accept_o);
  c_ack: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    flags_o.out2_fault ##1 !flags_o.out2_fault);
  c_conflict: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    load_conflict_error_o && !load_busy_o);

endmodule // counter_feedback_status

// ### testbench/host_xchg_model.sv
`timescale 1ns/10ps
// ==========================================================
// Host side: bus exchanges and status-clear handshake
// ==========================================================
module host_xchg_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clear_go_i,
  input wire logic status_clear_active_i,
  output logic xchg_o,
  output logic status_clear_req_o,
  output logic clear_busy_o
);
  logic [1:0] div_q;
  logic [2:0] seen_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 2'h0;
      xchg_o <= 1'b0;
      status_clear_req_o <= 1'b0;
      clear_busy_o <= 1'b0;
      seen_q <= 3'h0;
    end else begin
      div_q <= div_q + 2'h1;
      xchg_o <= (div_q == 2'h3); // One exchange every fourth cycle
      if (clear_go_i && !clear_busy_o) begin
        status_clear_req_o <= 1'b1;
        clear_busy_o <= 1'b1;
        seen_q <= 3'h0;
      end else if (status_clear_req_o && status_clear_active_i && xchg_o) begin
        seen_q <= seen_q + 3'h1;
        if (seen_q == 3'h3) status_clear_req_o <= 1'b0;
      end else if (!status_clear_req_o && !status_clear_active_i) begin
        clear_busy_o <= 1'b0;
      end
    end
  end
endmodule // host_xchg_model

// ### testbench/counter_feedback_status_tb.sv
`timescale 1ns/10ps
module counter_feedback_status_tb;
  import fb_status_pkg::*;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, xchg, req, active, go = 1'b0;
  logic busy_h, err_ack = 1'b0, stop = 1'b0, bad_val = 1'b0, bad_par = 1'b0;
  logic nmd = 1'b0, o1on = 1'b0, o2on = 1'b0, o1en = 1'b0, o2en = 1'b0;
  logic o1f = 1'b0, o2f = 1'b0, pin = 1'b0, gate = 1'b0, ce = 1'b1;
  logic pin_s, o1_s, o2_s, gate_s, lbusy, lacc, conf, serr;
  fault_src_t fsrc = '0;
  logic [3:0] den = 4'h0, diag;
  load_req_t lreq = '0;
  cnt_evt_t evt = '0;
  flags_t flg;
  int failures = 0, cmp_count = 0, cyc = 0, n, a;
  logic [9:0] rows [5] = '{10'h210, 10'h108, 10'h084, 10'h042, 10'h3FF};
  always #10 sys_clk_i = ~sys_clk_i;
  counter_feedback_status counter_feedback_status_i (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(ce), .xchg_i(xchg), .fault_src_i(fsrc),
    .diag_en_i(den), .error_ack_i(err_ack), .host_stop_i(stop),
    .load_req_i(lreq), .load_value_bad_i(bad_val), .param_bad_i(bad_par),
    .status_clear_req_i(req), .cnt_evt_i(evt), .no_main_dir_i(nmd),
    .out1_on_i(o1on), .out2_on_i(o2on), .out1_enable_i(o1en),
    .out2_enable_i(o2en), .out1_force_i(o1f), .out2_force_i(o2f),
    .input_pin_i(pin), .gate_open_i(gate), .input_pin_state_o(pin_s),
    .out1_state_o(o1_s), .out2_state_o(o2_s), .gate_open_state_o(gate_s),
    .load_busy_o(lbusy), .load_accept_o(lacc),
    .load_conflict_error_o(conf), .setting_error_o(serr),
    .status_clear_active_o(active), .flags_o(flg), .diag_msg_o(diag));
  host_xchg_model host_xchg_model_i (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .clear_go_i(go), .status_clear_active_i(active),
    .xchg_o(xchg), .status_clear_req_o(req), .clear_busy_o(busy_h));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    step(5);
    chk("reset flags", {flg}, 10'h000);
    rst_n_i = 1'b1;
    step(1);
    // Mirror rows: inputs beside expected outputs
    foreach (rows[i]) begin
      {pin, o1on, o2on, gate, bad_par} = rows[i][9:5];
      step(2);
      chk("mirror", {pin_s, o1_s, o2_s, gate_s, serr}, rows[i][4:0]);
    end
    $display("mirror test done");
    {pin, o1on, o2on, gate, bad_par} = 5'h00;
    for (int i = 0; i < 4; i++) begin
      den = i[0] ? 4'hF : 4'h0;
      fsrc = 4'h8 >> i;
      step(1);
      fsrc = '0;
      step(3);
      chk("fault latch", flg[9:6], 4'h8 >> i);
      chk("diag", diag, i[0] ? 4'h8 >> i : 4'h0);
      err_ack = 1'b1; // cause already removed
      step(2);
      err_ack = 1'b0;
      chk("fault ack", flg[9:6], 4'h0);
    end
    stop = 1'b1;
    fsrc = 4'hF;
    step(2);
    chk("live fault", flg[9:6], 4'hF);
    fsrc = '0;
    step(2);
    chk("live drop", flg[9:6], 4'h0);
    stop = 1'b0;
    // Clock enable low freezes the flags
    ce = 1'b0;
    fsrc = 4'h2;
    step(2);
    chk("frozen", flg[9:6], 4'h0);
    ce = 1'b1;
    step(1);
    fsrc = '0;
    chk("unfrozen", flg[9:6], 4'h2);
    err_ack = 1'b1; // cause already removed
    step(1);
    err_ack = 1'b0;
    chk("ack out2", flg[9:6], 4'h0);
    $display("fault test done");
    lreq = 5'h18;
    step(2);
    chk("two loads", {conf, lbusy}, 10'h2);
    lreq = 5'h10;
    bad_val = 1'b1;
    step(2);
    chk("bad value", {conf, lbusy}, 10'h2);
    bad_val = 1'b0;
    step(1);
    lreq = '0;
    n = 0;
    a = 0;
    for (int k = 0; k < 40 && (lbusy === 1'b1 || a == 0); k++) begin
      if (lbusy === 1'b1) n += xchg;
      a += lacc;
      step(1);
    end
    chk("load xchg", n, 3);
    chk("accept", {a, conf}, 10'h2);
    $display("load test done");
    nmd = 1'b0;
    evt = 4'h2;
    step(1);
    evt = '0;
    step(2);
    chk("zero gated", flg.zero_cross_flag, 10'h0);
    nmd = 1'b1;
    evt = 4'hF;
    o1on = 1'b1;
    o2f = 1'b1;
    step(1);
    {evt, o1on, o2f} = '0;
    o2on = 1'b1;
    step(6);
    chk("events", flg[5:0], 10'h3F);
    go = 1'b1;
    step(1);
    go = 1'b0;
    a = 0;
    for (int k = 0; k < 60 && busy_h === 1'b1; k++) begin
      a |= active;
      step(1);
    end
    step(1);
    chk("clear", {a, active, flg[5:0]}, 10'h090);
    o2on = 1'b0;
    o1en = 1'b1;
    o1f = 1'b1;
    step(2);
    chk("force1 enabled", flg.cmp1_flag, 10'h0);
    o1en = 1'b0;
    step(2);
    o1f = 1'b0;
    chk("force1", flg.cmp1_flag, 10'h1);
    $display("status test done");
    rst_n_i = 1'b0;
    step(1);
    chk("mid reset", {flg}, 10'h000);
    rst_n_i = 1'b1;
    step(2);
    chk("after reset", {flg}, 10'h000);
    $display("reset test done");
    summarize();
  end
endmodule // counter_feedback_status_tb
